// ===== src/aop_pkg.sv
package aop_pkg;
    // Pipeline depth from sample to output word
    localparam int PIPE_LATENCY = 21;
    // Extra cycle when input-to-output clock delay exceeds a period
    localparam int EXTRA_LATENCY = 1;
    localparam int WIDTH_WIDE = 14;
    localparam int WIDTH_NARROW = 12;
    localparam int GAIN_W = 3;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    // Gain step in tenths of dB, code n gives n steps
    localparam int GAIN_STEP_DB_X10 = 5;
    // Full-scale in millivolts at each gain code
    localparam logic [15:0] FS_MV [8] = '{16'h05DC, 16'h0582, 16'h0532, 16'h04EC,
                                          16'h04A6, 16'h0460, 16'h0424, 16'h03E8};
    localparam int FIFO_DEPTH = 16;

    // Output mode
    typedef enum logic [0:0] {
        AOP_MODE_DDR = 1'b0,
        AOP_MODE_CMOS = 1'b1
    } aop_mode_t;

    // Word travelling through pipeline and FIFO
    typedef struct packed {
        logic [WIDTH_WIDE-1:0] data;
    } aop_word_t;
endpackage

// ===== src/aop_fifo.sv
`timescale 1ns/1ps
module aop_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic push;
    logic pop;

    // Honest full and empty from pointer difference
    assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_r != rd_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_r[AW-1:0]];

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

// ===== src/aop_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: Sample input on each conversion clock rise
// R2: Output word appears 21 cycles later
// R3: Add one cycle when clock delay long
// R4: Fourteen or twelve bit words, two forms
// R5: Offset binary or twos complement format
// R6: DDR lane carries even and odd bit
// R7: CMOS drives every bit on own line
// R8: Controller pulses reset high for serial
// R9: Parallel configuration holds reset high always
// R10: Gain zero to 3.5 dB, 0.5 steps
// R11: Reset selects zero dB gain
// R12: Gain shrinks full-scale 1.5 to 1 Vpp
// R13: Even bits fall edge, odd bits rise
// R14: Mode chosen by register bit or pin
// R15: Receiver latches CMOS words on rise
// R16: Three-bit gain code, n half-dB steps
// R17: Output clock follows input clock phase
module aop_top
    import aop_pkg::*;
#(
    parameter int WIDTH = WIDTH_WIDE,
    parameter int DEPTH = FIFO_DEPTH
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Conversion clock from outside, sampled
    input wire logic sample_clk,
    // Raw quantiser result, offset binary
    input wire logic [WIDTH-1:0] sample_in,
    // Configuration
    input wire logic mode_reg_sel,
    input wire logic mode_reg_cmos,
    input wire logic interface_select_pin,
    input wire logic twos_comp,
    input wire logic long_clk_delay,
    input wire logic [GAIN_W-1:0] gain_code,
    input wire logic gain_load,
    // Outputs
    output logic [WIDTH/2-1:0] ddr_lane,
    output logic output_clock_pos,
    output logic [WIDTH-1:0] cmos_data,
    output logic cmos_output_clock,
    output logic [GAIN_W-1:0] gain_r,
    output logic [15:0] full_scale_mv,
    output logic overflow
);
    localparam int TOTAL = PIPE_LATENCY + EXTRA_LATENCY;
    localparam int HALF = WIDTH / 2;

    logic [2:0] sck_sync_r;
    logic sck_rise;
    logic sck_fall;
    logic [WIDTH-1:0] pipe_r [TOTAL];
    logic [TOTAL-1:0] vld_r;
    logic [WIDTH-1:0] word_tap;
    logic word_vld;
    logic fifo_ready;
    logic out_vld;
    logic [WIDTH-1:0] out_word;
    logic [WIDTH-1:0] word_r;
    logic [HALF-1:0] even_bit_slot;
    logic [HALF-1:0] odd_bit_slot;
    aop_mode_t mode;
    logic sck_in;
    logic [4:0] rise_cnt_r;

    // Two-flop sync; second and third stages feed edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_sync_r <= 3'h0;
        end else begin
            sck_sync_r <= {sck_sync_r[1:0], sample_clk};
        end
    end
    assign sck_in = sck_sync_r[1];
    assign sck_rise = sck_in && !sck_sync_r[2]; // see R1
    assign sck_fall = !sck_in && sck_sync_r[2];

    // Register bit overrides pin when selected
    assign mode = mode_reg_sel ? aop_mode_t'(mode_reg_cmos) : aop_mode_t'(interface_select_pin); // see R14

    // Gain code, zero dB after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_r <= GAIN_RESET; // see R11
        end else if (gain_load) begin
            gain_r <= gain_code; // see R10, see R16
        end
    end
    // Full-scale is informational, analog does the scaling
    assign full_scale_mv = FS_MV[gain_r]; // see R12

    // Pipeline advances one stage per sample edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vld_r <= '0;
        end else if (sck_rise) begin
            vld_r <= {vld_r[TOTAL-2:0], 1'b1}; // see R2
        end
    end
    always_ff @(posedge clk) begin
        if (sck_rise) begin
            pipe_r[0] <= twos_comp ? {~sample_in[WIDTH-1], sample_in[WIDTH-2:0]} : sample_in; // see R5
        end
    end
    for (genvar i = 1; i < TOTAL; i++) begin : g_pipe
        always_ff @(posedge clk) begin
            if (sck_rise) begin
                pipe_r[i] <= pipe_r[i-1]; // see R2
            end
        end
    end

    // Tap at 21 or 22 stages
    assign word_tap = long_clk_delay ? pipe_r[TOTAL-1] : pipe_r[PIPE_LATENCY-1]; // see R3
    assign word_vld = sck_rise && (long_clk_delay ? vld_r[TOTAL-1] : vld_r[PIPE_LATENCY-1]);

    // FIFO absorbs sync jitter; drained one word per falling sample edge
    aop_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(word_vld),
        .in_ready(fifo_ready),
        .in_data(word_tap),
        .out_valid(out_vld),
        .out_ready(sck_fall),
        .out_data(out_word)
    );

    // Drops show as sticky overflow rather than silent loss
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow <= 1'b0;
        end else if (word_vld && !fifo_ready) begin
            overflow <= 1'b1;
        end
    end

    // Word updated at falling sample edge, mid-period of output clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_r <= '0;
        end else if (sck_fall && out_vld) begin
            word_r <= out_word; // see R4, see R7
        end
    end

    for (genvar b = 0; b < HALF; b++) begin : g_lane
        assign even_bit_slot[b] = word_r[2*b];
        assign odd_bit_slot[b] = word_r[2*b+1]; // see R6
    end

    // Clock copies follow the synced input clock: fixed phase to data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_clock_pos <= 1'b0;
            cmos_output_clock <= 1'b0;
        end else begin
            output_clock_pos <= (mode == AOP_MODE_DDR) ? sck_in : 1'b0; // see R17
            cmos_output_clock <= (mode == AOP_MODE_CMOS) ? sck_in : 1'b0; // see R17, see R15
        end
    end

    // Even bits launched while clock low, odd while high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ddr_lane <= '0;
            cmos_data <= '0;
        end else begin
            ddr_lane <= (mode == AOP_MODE_DDR) ? (sck_in ? odd_bit_slot : even_bit_slot) : '0; // see R13
            cmos_data <= (mode == AOP_MODE_CMOS) ? word_r : '0; // see R7
        end
    end

    // Sample edges since reset, saturating; an independent view of pipeline fill
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rise_cnt_r <= 5'h0;
        end else if (sck_rise && rise_cnt_r != 5'(TOTAL)) begin
            rise_cnt_r <= rise_cnt_r + 5'h1;
        end
    end

    // Checks
    chk_gain_reset: assert property (@(posedge clk) $rose(rst_n) |-> gain_r == 3'h0) // see R11
        else $error("gain not zero after reset");
    chk_gain_load: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        gain_load |=> gain_r == $past(gain_code))
        else $error("gain load failed");
    chk_fs_top: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        gain_r == 3'h7 |-> full_scale_mv == 16'h03E8)
        else $error("full scale wrong at max gain");
    chk_mode_pin: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        !mode_reg_sel |-> mode == aop_mode_t'(interface_select_pin))
        else $error("mode not from pin");
    chk_clk_follow: assert property (@(posedge clk) disable iff (!rst_n) // see R17
        mode == AOP_MODE_DDR && $stable(mode) |=> output_clock_pos == $past(sck_in))
        else $error("output clock lost phase");
    chk_ddr_odd: assert property (@(posedge clk) disable iff (!rst_n) // see R13
        mode == AOP_MODE_DDR && sck_in |=> ddr_lane == $past(odd_bit_slot))
        else $error("odd bits not on high phase");
    chk_ddr_even: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        mode == AOP_MODE_DDR && !sck_in |=> ddr_lane == $past(even_bit_slot))
        else $error("even bits not on low phase");
    chk_cmos_data: assert property (@(posedge clk) disable iff (!rst_n) // see R7
        mode == AOP_MODE_CMOS |=> cmos_data == $past(word_r))
        else $error("cmos data mismatch");
    chk_pipe_vld: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        word_vld |-> rise_cnt_r >= (long_clk_delay ? 5'(TOTAL) : 5'(PIPE_LATENCY)))
        else $error("word before pipeline filled");
    chk_tap_long: assert property (@(posedge clk) disable iff (!rst_n) // see R3
        long_clk_delay |-> word_tap == pipe_r[TOTAL-1])
        else $error("extra latency not applied");
    cov_ddr: cover property (@(posedge clk) disable iff (!rst_n) mode == AOP_MODE_DDR && word_vld);
    cov_cmos: cover property (@(posedge clk) disable iff (!rst_n) mode == AOP_MODE_CMOS && word_vld);
    cov_gain: cover property (@(posedge clk) disable iff (!rst_n) gain_load ##1 gain_r == 3'h7);
    cov_long: cover property (@(posedge clk) disable iff (!rst_n) long_clk_delay && twos_comp && word_vld);
endmodule

// ===== tb/aop_rx_model.sv
`timescale 1ns/1ps
module aop_rx_model
    import aop_pkg::*;
#(
    parameter int WIDTH = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device outputs
    input wire logic [WIDTH/2-1:0] ddr_lane,
    input wire logic output_clock_pos,
    input wire logic [WIDTH-1:0] cmos_data,
    input wire logic cmos_output_clock,
    // Rebuilt word
    output logic word_valid,
    output logic [WIDTH-1:0] word
);
    logic ddr_prev_r;
    logic ddr_late_r;
    logic cmos_prev_r;
    logic [WIDTH/2-1:0] even_r;
    // Edges found on the system clock; data is registered with its clock
    always_ff @(posedge clk) begin
        ddr_prev_r <= output_clock_pos;
        ddr_late_r <= ddr_prev_r;
        cmos_prev_r <= cmos_output_clock;
        word_valid <= 1'b0;
        // Even bits settle one cycle after the clock falls, so take them a cycle late
        if (ddr_late_r && !ddr_prev_r && !output_clock_pos) begin
            even_r <= ddr_lane;
        end
        if (!ddr_prev_r && output_clock_pos) begin
            for (int b = 0; b < WIDTH / 2; b++) begin
                word[2*b] <= even_r[b];
                word[2*b+1] <= ddr_lane[b];
            end
            word_valid <= rst_n;
        end
        // Latched on the rise only; a fall tells us nothing
        if (!cmos_prev_r && cmos_output_clock) begin
            word <= cmos_data;
            word_valid <= rst_n;
        end
    end
endmodule

// ===== tb/adc_output_pipeline_gain_test.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end cmp_count++; end
module adc_output_pipeline_gain_test;
    import aop_pkg::*;
    logic clk, rst_n, sample_clk, gain_load, rx_valid, cmos_sel;
    logic mode_reg_sel, mode_reg_cmos, interface_select_pin, twos_comp, long_clk_delay;
    logic [13:0] sample_in, cmos_data, rx_word, s, exp_w;
    logic [6:0] ddr_lane;
    logic output_clock_pos, cmos_output_clock, overflow;
    logic [2:0] gain_code, gain_r;
    logic [15:0] full_scale_mv;
    logic [15:0] fs_tab [8] = '{16'h05DC, 16'h0582, 16'h0532, 16'h04EC, 16'h04A6, 16'h0460, 16'h0424, 16'h03E8};
    logic [13:0] exp_q [$];
    int seed = 16974;
    int miscompares = 0;
    int cmp_count = 0;
    int lat, base;
    aop_top dut_u (.clk(clk), .rst_n(rst_n), .sample_clk(sample_clk), .sample_in(sample_in),
        .mode_reg_sel(mode_reg_sel), .mode_reg_cmos(mode_reg_cmos), .interface_select_pin(interface_select_pin),
        .twos_comp(twos_comp), .long_clk_delay(long_clk_delay), .gain_code(gain_code), .gain_load(gain_load),
        .ddr_lane(ddr_lane), .output_clock_pos(output_clock_pos), .cmos_data(cmos_data),
        .cmos_output_clock(cmos_output_clock), .gain_r(gain_r), .full_scale_mv(full_scale_mv), .overflow(overflow));
    aop_rx_model rx_u (.clk(clk), .rst_n(rst_n), .ddr_lane(ddr_lane), .output_clock_pos(output_clock_pos),
        .cmos_data(cmos_data), .cmos_output_clock(cmos_output_clock), .word_valid(rx_valid), .word(rx_word));
    always #20 clk = ~clk;
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset, then stream n samples; reset between phases keeps latency counting clean
    task automatic run_phase(input logic [4:0] cfg, input int n);
        {mode_reg_sel, mode_reg_cmos, interface_select_pin, twos_comp, long_clk_delay} = cfg;
        cmos_sel = cfg[4] ? cfg[3] : cfg[2];
        lat = cfg[0] ? PIPE_LATENCY + EXTRA_LATENCY : PIPE_LATENCY;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        exp_q.delete();
        base = cmp_count;
        `CHECK(gain_r, GAIN_RESET)
        for (int i = 0; i < n; i++) begin
            s = 14'($random(seed));
            sample_in = s;
            repeat (4) @(negedge clk);
            sample_clk = 1'b1;
            exp_q.push_back(twos_comp ? {~s[13], s[12:0]} : s);
            repeat (4) @(negedge clk);
            sample_clk = 1'b0;
        end
        repeat (8) @(negedge clk);
        `CHECK(cmp_count - base, 2 * (n - lat - 1) + 1)
    endtask
    // Receiver side: the oldest note goes once enough samples have followed it
    always @(negedge clk) begin
        if (rx_valid === 1'b1 && exp_q.size() > lat + 1) begin
            exp_w = exp_q.pop_front();
            `CHECK(rx_word, exp_w)
            if (cmos_sel) `CHECK(output_clock_pos, 1'b0)
            else `CHECK(cmos_output_clock, 1'b0)
        end
    end
    initial begin
        #4000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sample_clk = 1'b0;
        sample_in = '0;
        {mode_reg_sel, mode_reg_cmos, interface_select_pin, twos_comp, long_clk_delay} = '0;
        gain_code = '0;
        gain_load = 1'b0;
        lat = 21;
        cmos_sel = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHECK(full_scale_mv, 16'h05DC)
        // Every code, ending on the top one so the next reset has work to do
        for (int c = 0; c < 8; c++) begin
            gain_code = c[2:0];
            gain_load = 1'b1;
            @(negedge clk);
            gain_load = 1'b0;
            @(negedge clk);
            `CHECK(gain_r, c[2:0])
            `CHECK(full_scale_mv, fs_tab[c])
        end
        run_phase(5'b10000, 40);
        run_phase(5'b11010, 40);
        run_phase(5'b00101, 40);
        run_phase(5'b01011, 40);
        `CHECK(overflow, 1'b0)
        print_verdict();
    end
endmodule
